// ---- verilog/sfs_pkg.sv ----
/*
  sfs_pkg: constants, register map and carrier types of the serial fifo
  status flag block.
  assumes: shared by sfs_fifo and sfs_status; no timing beyond pclk.
*/
`default_nettype none

package sfs_pkg;

  // ==========================================================================
  // apb register map (byte addresses, one 32-bit word each)
  localparam int unsigned     PADDR_W     = 12;
  localparam logic [11:0]     OFS_STATUS  = 12'h000;
  localparam logic [11:0]     OFS_TXDATA  = 12'h004;
  localparam logic [11:0]     OFS_RXDATA  = 12'h008;
  localparam logic [11:0]     OFS_CTRL    = 12'h00c;

  // ==========================================================================
  // serial_status layout
  localparam logic [15:0]     STATUS_RST  = 16'h0060;
  localparam int unsigned     BIT_ER      = 7;
  localparam int unsigned     BIT_TX_END_FLAG    = 6;
  localparam int unsigned     BIT_TX_FIFO_LOW_FLAG    = 5;
  localparam int unsigned     BIT_BRK     = 4;
  localparam int unsigned     BIT_FER     = 3;
  localparam int unsigned     BIT_PER     = 2;
  localparam int unsigned     BIT_RDF     = 1;
  localparam int unsigned     BIT_DR      = 0;
  // bits that are sticky flags cleared by read-one-then-write-zero
  localparam logic [7:0]      FLAG_MASK   = 8'hf3;
  localparam int unsigned     ECNT_W      = 4;
  localparam logic [3:0]      ECNT_MAX    = 4'hf;

  // ==========================================================================
  // fifo sizing and trigger tables
  localparam int unsigned     FIFO_DEPTH  = 16;
  localparam int unsigned     CNT_W       = 5;
  localparam logic [4:0]      DEPTH_C     = 5'h10;
  localparam logic [4:0]      TX_TRIG_TAB [0:3] = '{5'h08, 5'h04, 5'h02, 5'h01};
  localparam logic [4:0]      RX_TRIG_TAB [0:3] = '{5'h01, 5'h04, 5'h08, 5'h0e};

  // ==========================================================================
  // serial_control word, bit 0 upward: tx trigger, rx trigger, enables, parity
  localparam int unsigned     CTRL_W      = 8;
  typedef struct packed {
    logic       par_odd;
    logic       par_en;
    logic       rx_en;
    logic       tx_en;
    logic [1:0] rx_trig_sel;
    logic [1:0] tx_trig_sel;
  } sfs_ctrl_s;
  localparam sfs_ctrl_s       CTRL_RST    = '0;

  // one received frame as delivered by the framing datapath
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       parity_bit;
    logic       stop_first;
  } sfs_rx_evt_s;

  // one entry of the receive fifo
  typedef struct packed {
    logic       word_parity_error;
    logic       word_framing_error;
    logic [7:0] data;
  } sfs_rx_word_s;
  localparam int unsigned     RXW_W       = 10;

endpackage

`default_nettype wire

// ---- verilog/sfs_fifo.sv ----
/*
  sfs_fifo: flip-flop fifo with occupancy count and synchronous flush.
  assumes: caller never pushes when full nor pops when empty.
*/
`timescale 1ns/1ps
`default_nettype none

module sfs_fifo
  import sfs_pkg::*;
#(
  parameter int unsigned W     = 8,
  parameter int unsigned DEPTH = FIFO_DEPTH,
  parameter int unsigned AW    = 4
) (
  input  wire logic           pclk,
  input  wire logic           presetn,
  input  wire logic           flush,
  input  wire logic           push,
  input  wire logic [W-1:0]   din,
  input  wire logic           pop,
  output logic      [W-1:0]   dout,
  output logic      [AW:0]    count,
  output logic                empty,
  output logic                full
);

  // ==========================================================================
  // storage
  logic [W-1:0]  mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;

  genvar i;
  generate
    for (i = 0; i < DEPTH; i++) begin : g_ent
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          mem_q[i] <= '0;
        end else if (push && wr_q == AW'(i)) begin
          mem_q[i] <= din;
        end
      end
    end
  endgenerate

  // ==========================================================================
  // pointers and count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else if (flush) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  assign dout  = mem_q[rd_q];
  assign count = cnt_q;
  assign empty = (cnt_q == '0);
  assign full  = (cnt_q == (AW+1)'(DEPTH));

endmodule

`default_nettype wire

// ---- verilog/sfs_status.sv ----
/*
  sfs_status: status flags, transmit/receive fifos and error counts of the
  asynchronous serial port, with an apb3 slave for serial_status, fifo data
  and serial_control.
  assumes: the shift/framing datapath runs on pclk and hands over frames and
  events as one-cycle pulses; standby inputs are pclk-synchronous levels;
  rx_pin is asynchronous.
*/
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module sfs_status
  import sfs_pkg::*;
#(
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [PADDR_W-1:0]  paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                standby,
  input  wire logic                module_standby,
  input  wire logic                rx_pin,
  input  wire sfs_rx_evt_s         rx_evt,
  input  wire logic                rx_idle_timeout,
  input  wire logic                tx_take,
  input  wire logic                tx_char_done,
  output logic      [7:0]          tx_byte,
  output logic                     tx_byte_valid,
  output sfs_ctrl_s                serial_control
);

  // ==========================================================================
  // declarations
  logic [31:0]        prdata_q;
  logic               pready_q;
  logic               pslverr_q;
  logic               acc_first;
  logic               acc_done;
  logic               addr_hit;
  logic [31:0]        rd_mux;
  logic               wr_status;
  logic               wr_txdata;
  logic               rd_status;
  logic               rd_rxdata;
  sfs_ctrl_s          ctrl_q;
  logic               stby;
  logic               rx_meta_q;
  logic               rx_line_q;
  logic [7:0]         flag_q;
  logic [7:0]         seen_q;
  logic [7:0]         hw_set;
  logic [7:0]         hw_clr;
  logic [7:0]         sw_clr;
  logic [4:0]         tx_trig;
  logic [4:0]         rx_trig;
  logic               tx_push;
  logic               tx_pop;
  logic               tx_accept;
  logic [7:0]         tx_head;
  logic [CNT_W-1:0]   tx_cnt;
  logic [CNT_W-1:0]   tx_cnt_nxt;
  logic               tx_empty;
  logic               tx_full;
  logic [CNT_W-1:0]   tx_fifo_low_flag_wr_q;
  logic [7:0]         tx_byte_q;
  logic               tx_byte_valid_q;
  logic               fer_now;
  logic               per_now;
  logic               brk_det;
  logic               prev_fer_q;
  logic               brk_hold_q;
  logic               rx_store;
  logic               rx_push;
  logic               rx_pop;
  sfs_rx_word_s       rx_in;
  sfs_rx_word_s       rx_head;
  logic [CNT_W-1:0]   rx_cnt;
  logic [CNT_W-1:0]   rx_cnt_nxt;
  logic               rx_empty;
  logic               rx_full;
  logic [CNT_W-1:0]   pcnt_q;
  logic [CNT_W-1:0]   fcnt_q;
  logic [15:0]        status_val;

  function automatic logic [ECNT_W-1:0] sat_cnt(input logic [CNT_W-1:0] c);
    sat_cnt = (c > CNT_W'(ECNT_MAX)) ? ECNT_MAX : c[ECNT_W-1:0];
  endfunction

  // ==========================================================================
  // apb slave: one wait state, answer registered in the access phase
  assign acc_first = psel & penable & ~pready_q;
  assign acc_done  = psel & penable & pready_q;
  assign addr_hit  = (paddr == OFS_STATUS) | (paddr == OFS_TXDATA) |
                     (paddr == OFS_RXDATA) | (paddr == OFS_CTRL);
  assign wr_status = acc_done & pwrite & (paddr == OFS_STATUS);
  assign wr_txdata = acc_done & pwrite & (paddr == OFS_TXDATA);
  assign rd_status = acc_done & ~pwrite & (paddr == OFS_STATUS);
  assign rd_rxdata = acc_done & ~pwrite & (paddr == OFS_RXDATA);

  always_comb begin
    rd_mux = '0;
    case (paddr)
      OFS_STATUS: rd_mux = {16'h0000, status_val};
      OFS_TXDATA: rd_mux = {16'h0000, 3'h0, tx_cnt, 8'h00};
      OFS_RXDATA: rd_mux = {24'h000000, rx_head.data};
      OFS_CTRL:   rd_mux = {24'h000000, ctrl_q};
      default:    rd_mux = '0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      prdata_q  <= '0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= acc_first;
      if (acc_first) begin
        prdata_q  <= pwrite ? 32'h00000000 : rd_mux;
        pslverr_q <= ~addr_hit;
      end else begin
        pslverr_q <= 1'b0;
      end
    end
  end

  // rx enable only gates new frames; the flags keep their state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RST;
    end else if (acc_done && pwrite && paddr == OFS_CTRL) begin
      ctrl_q <= sfs_ctrl_s'(pwdata[CTRL_W-1:0]);
    end
  end

  assign stby    = standby | module_standby;
  assign tx_trig = TX_TRIG_TAB[ctrl_q.tx_trig_sel];
  assign rx_trig = RX_TRIG_TAB[ctrl_q.rx_trig_sel];

  // ==========================================================================
  // rx line synchroniser, idles at mark
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_meta_q <= 1'b1;
      rx_line_q <= 1'b1;
    end else begin
      rx_meta_q <= rx_pin;
      rx_line_q <= rx_meta_q;
    end
  end

  // ==========================================================================
  // transmit fifo
  // writes past the budget are dropped silently; software must poll the count
  assign tx_accept = ~tx_full &
                     (~flag_q[BIT_TX_FIFO_LOW_FLAG] | (tx_fifo_low_flag_wr_q < (DEPTH_C - tx_trig)));
  assign tx_push   = wr_txdata & tx_accept;
  assign tx_pop    = tx_take & ctrl_q.tx_en & ~tx_empty;
  assign tx_cnt_nxt = tx_cnt + CNT_W'(tx_push) - CNT_W'(tx_pop);

  sfs_fifo #(
    .W     (8),
    .DEPTH (DEPTH),
    .AW    (CNT_W-1)
  ) u_tx_fifo (
    .pclk    (pclk),
    .presetn (presetn),
    .flush   (stby),
    .push    (tx_push),
    .din     (pwdata[7:0]),
    .pop     (tx_pop),
    .dout    (tx_head),
    .count   (tx_cnt),
    .empty   (tx_empty),
    .full    (tx_full)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_fifo_low_flag_wr_q <= '0;
    end else if (stby || !flag_q[BIT_TX_FIFO_LOW_FLAG]) begin
      tx_fifo_low_flag_wr_q <= '0;
    end else if (tx_push) begin
      tx_fifo_low_flag_wr_q <= tx_fifo_low_flag_wr_q + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_byte_q       <= '0;
      tx_byte_valid_q <= 1'b0;
    end else begin
      tx_byte_valid_q <= tx_pop;
      if (tx_pop) begin
        tx_byte_q <= tx_head;
      end
    end
  end

  // ==========================================================================
  // receive side: error check, break tracking, fifo
  assign fer_now  = ~rx_evt.stop_first;
  assign per_now  = ctrl_q.par_en &
                    ((^{rx_evt.data, rx_evt.parity_bit}) != ctrl_q.par_odd);
  assign brk_det  = rx_evt.valid & ctrl_q.rx_en & fer_now & prev_fer_q & ~rx_line_q;
  // the break frame itself is still stored; hold starts afterwards
  assign rx_store = rx_evt.valid & ctrl_q.rx_en & ~brk_hold_q;
  assign rx_push  = rx_store & ~rx_full;
  assign rx_pop   = rd_rxdata & ~rx_empty;
  assign rx_in    = '{word_parity_error: per_now, word_framing_error: fer_now, data: rx_evt.data};
  assign rx_cnt_nxt = rx_cnt + CNT_W'(rx_push) - CNT_W'(rx_pop);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_fer_q <= 1'b0;
      brk_hold_q <= 1'b0;
    end else if (stby) begin
      prev_fer_q <= 1'b0;
      brk_hold_q <= 1'b0;
    end else begin
      if (rx_evt.valid && ctrl_q.rx_en) begin
        prev_fer_q <= fer_now;
      end
      if (brk_det) begin
        brk_hold_q <= 1'b1;
      end else if (rx_line_q) begin
        brk_hold_q <= 1'b0;
      end
    end
  end

  sfs_fifo #(
    .W     (RXW_W),
    .DEPTH (DEPTH),
    .AW    (CNT_W-1)
  ) u_rx_fifo (
    .pclk    (pclk),
    .presetn (presetn),
    .flush   (stby),
    .push    (rx_push),
    .din     (rx_in),
    .pop     (rx_pop),
    .dout    (rx_head),
    .count   (rx_cnt),
    .empty   (rx_empty),
    .full    (rx_full)
  );

  // receive-fifo parity and framing error counts follow words in and out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pcnt_q <= '0;
      fcnt_q <= '0;
    end else if (stby) begin
      pcnt_q <= '0;
      fcnt_q <= '0;
    end else begin
      pcnt_q <= pcnt_q + CNT_W'(rx_push & rx_in.word_parity_error) - CNT_W'(rx_pop & rx_head.word_parity_error);
      fcnt_q <= fcnt_q + CNT_W'(rx_push & rx_in.word_framing_error) - CNT_W'(rx_pop & rx_head.word_framing_error);
    end
  end

  // ==========================================================================
  // flag events
  always_comb begin
    hw_set = '0;
    hw_clr = '0;
    hw_set[BIT_ER]   = rx_store & (fer_now | per_now);
    hw_set[BIT_TX_END_FLAG] = (tx_char_done & tx_empty & ~tx_push) | ~ctrl_q.tx_en;
    hw_clr[BIT_TX_END_FLAG] = tx_push;
    hw_set[BIT_TX_FIFO_LOW_FLAG] = tx_pop & (tx_cnt_nxt < tx_trig);
    hw_clr[BIT_TX_FIFO_LOW_FLAG] = tx_push & (tx_cnt_nxt > tx_trig);
    hw_set[BIT_BRK]  = brk_det;
    hw_set[BIT_RDF]  = rx_push & (rx_cnt_nxt >= rx_trig);
    hw_set[BIT_DR]   = rx_idle_timeout & (rx_cnt < rx_trig) & ~rx_empty;
  end

  // only zeros written to flags already seen as one clear them
  assign sw_clr = {8{wr_status}} & ~pwdata[7:0] & seen_q & FLAG_MASK;

  genvar b;
  generate
    for (b = 0; b < 8; b++) begin : g_flag
      if (FLAG_MASK[b]) begin : g_sticky
        always_ff @(posedge pclk or negedge presetn) begin
          if (!presetn) begin
            flag_q[b] <= STATUS_RST[b];
            seen_q[b] <= 1'b0;
          end else if (stby) begin
            flag_q[b] <= STATUS_RST[b];
            seen_q[b] <= 1'b0;
          end else if (hw_set[b]) begin
            flag_q[b] <= 1'b1;
          end else if (hw_clr[b] || sw_clr[b]) begin
            flag_q[b] <= 1'b0;
            seen_q[b] <= 1'b0;
          end else if (rd_status && prdata_q[b] && flag_q[b]) begin
            seen_q[b] <= 1'b1;
          end
        end
      end else begin : g_ro
        assign flag_q[b] = 1'b0;
        assign seen_q[b] = 1'b0;
      end
    end
  endgenerate

  // ==========================================================================
  // serial_status view
  always_comb begin
    status_val                    = {sat_cnt(pcnt_q), sat_cnt(fcnt_q), flag_q};
    status_val[BIT_FER]           = ~rx_empty & rx_head.word_framing_error;
    status_val[BIT_PER]           = ~rx_empty & rx_head.word_parity_error;
  end

  assign prdata         = prdata_q;
  assign pready         = pready_q;
  assign pslverr        = pslverr_q;
  assign tx_byte        = tx_byte_q;
  assign tx_byte_valid  = tx_byte_valid_q;
  assign serial_control = ctrl_q;

endmodule

`default_nettype wire

// ---- tb/sfs_status_properties.sv ----
/* sfs_status_properties: apb and flag checks on the sfs_status ports.
   assumes: one pclk domain, bound below to every sfs_status. */
`timescale 1ns/1ps
`default_nettype none
module sfs_status_properties
  import sfs_pkg::*;
(
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic [31:0]        pwdata,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire logic               standby,
  input wire logic               module_standby,
  input wire logic               tx_take,
  input wire logic               tx_byte_valid,
  input wire sfs_ctrl_s          serial_control
);
  // ==========================================================================
  // helpers
  logic mapped;
  logic rd_st;
  logic sb;
  assign mapped = paddr inside {OFS_STATUS, OFS_TXDATA, OFS_RXDATA, OFS_CTRL};
  assign rd_st  = pready && !pwrite && paddr == OFS_STATUS;
  assign sb     = standby || module_standby;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================================
  // properties
  property p_wait; psel && penable && !pready |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("no answer after one wait state");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
  property p_cause; pready |-> $past(psel && penable); endproperty
  a_cause: assert property (p_cause) else $error("pready without access phase");
  property p_err; pready |-> pslverr == !mapped; endproperty
  a_err: assert property (p_err) else $error("pslverr does not match address map");
  property p_err_q; !pready |-> !pslverr; endproperty
  a_err_q: assert property (p_err_q) else $error("pslverr outside answer");
  property p_hi; rd_st |-> prdata[31:16] == 16'h0000; endproperty
  a_hi: assert property (p_hi) else $error("status upper half not zero");
  property p_txv;
    pready && !pwrite && paddr == OFS_TXDATA |-> prdata[7:0] == 8'h00 && prdata[15:8] <= 8'h10;
  endproperty
  a_txv: assert property (p_txv) else $error("tx fifo view malformed");
  property p_ctrl;
    psel && penable && pready && pwrite && paddr == OFS_CTRL |=> serial_control == $past(pwdata[7:0]);
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("control write lost");
  property p_txb; tx_byte_valid |-> $past(tx_take) && $past(serial_control.tx_en); endproperty
  a_txb: assert property (p_txb) else $error("tx byte without take");
  property p_sb; sb ##1 sb ##1 rd_st |-> prdata[15:0] == STATUS_RST; endproperty
  a_sb: assert property (p_sb) else $error("status not initial in standby");
  property p_tx_end_flag; (!serial_control.tx_en) [*3] ##0 rd_st |-> prdata[BIT_TX_END_FLAG]; endproperty
  a_tx_end_flag: assert property (p_tx_end_flag) else $error("tx end clear while disabled");
  c_rx: cover property (pready && !pwrite && paddr == OFS_RXDATA);
  c_tx: cover property (tx_byte_valid);
  c_err: cover property (pslverr);
endmodule
bind sfs_status sfs_status_properties u_sfs_status_properties (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .standby(standby), .module_standby(module_standby), .tx_take(tx_take),
  .tx_byte_valid(tx_byte_valid), .serial_control(serial_control));
`default_nettype wire

// ---- tb/sfs_remote.sv ----
/* sfs_remote: far end of the serial line, reduced to frames and strobes.
   assumes: tasks are called right after a pclk rising edge. */
`timescale 1ns/1ps
`default_nettype none
module sfs_remote
  import sfs_pkg::*;
(
  input  wire logic   pclk,
  output logic        rx_pin,
  output sfs_rx_evt_s rx_evt,
  output logic        rx_idle_timeout,
  output logic        tx_take,
  output logic        tx_char_done
);
  initial begin
    rx_pin = 1'b1;
    rx_evt = '0;
    {tx_take, tx_char_done, rx_idle_timeout} = 3'h0;
  end
  // ==========================================================================
  // one frame; a bad stop bit leaves the line at space, so two make a break
  task automatic frame(input logic [7:0] d, input logic bad_par, input logic bad_stop,
                       input int gap);
    rx_pin <= !bad_stop;
    repeat (3) @(posedge pclk);
    rx_evt <= {1'b1, d, ^d ^ bad_par, !bad_stop};
    @(posedge pclk);
    rx_evt <= {1'b0, ~d, ~(^d), 1'b0};
    repeat (gap) @(posedge pclk);
  endtask
  // ==========================================================================
  // strobes: {tx_take, tx_char_done, rx_idle_timeout}
  task automatic pulse(input logic [2:0] p);
    {tx_take, tx_char_done, rx_idle_timeout} <= p;
    @(posedge pclk);
    {tx_take, tx_char_done, rx_idle_timeout} <= 3'h0;
    @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// ---- tb/serial_fifo_status_flags_tb.sv ----
/* serial_fifo_status_flags_tb: apb master, remote end and scoreboard for sfs_status.
   assumes: register map and trigger tables of sfs_pkg. */
`timescale 1ns/1ps
`default_nettype none
module serial_fifo_status_flags_tb
  import sfs_pkg::*;
;
  logic               pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic               standby, module_standby, rx_pin, rx_idle_timeout;
  logic               tx_take, tx_char_done, tx_byte_valid;
  logic [PADDR_W-1:0] paddr;
  logic [31:0]        pwdata, prdata;
  logic [7:0]         tx_byte, b;
  sfs_rx_evt_s        rx_evt;
  sfs_ctrl_s          serial_control;
  int                 failures, samples_checked, seed, i;
  logic [32:0]        rd_q[$];
  logic [7:0]         tx_q[$];
  logic [15:0]        st [3] = '{16'h11e6, 16'h01ea, 16'h00e2};

  sfs_status u_sfs_status (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .standby(standby), .module_standby(module_standby), .rx_pin(rx_pin), .rx_evt(rx_evt),
    .rx_idle_timeout(rx_idle_timeout), .tx_take(tx_take), .tx_char_done(tx_char_done),
    .tx_byte(tx_byte), .tx_byte_valid(tx_byte_valid), .serial_control(serial_control));
  sfs_remote u_sfs_remote (
    .pclk(pclk), .rx_pin(rx_pin), .rx_evt(rx_evt), .rx_idle_timeout(rx_idle_timeout),
    .tx_take(tx_take), .tx_char_done(tx_char_done));

  initial pclk = 1'b0;
  always #2 pclk = ~pclk;
  // ==========================================================================
  // scoreboard
  task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      check("apb read", {pslverr, prdata}, rd_q.size() ? rd_q.pop_front() : 33'h0);
    end
    if (tx_byte_valid === 1'b1) begin
      check("tx byte", {24'h0, 1'b1, tx_byte}, tx_q.size() ? {24'h0, 1'b1, tx_q.pop_front()} : 33'h0);
    end
  end
  task automatic results();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ==========================================================================
  // apb master: waits for pready, never assumes the wait count
  task automatic apb(input logic wr, input logic [PADDR_W-1:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // a hung slave is caught by the watchdog, which ends the run
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [PADDR_W-1:0] a, input logic [32:0] e);
    rd_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic txw(input int n, input int keep);
    for (int k = 0; k < n; k++) begin
      b = 8'($random(seed));
      if (k < keep) tx_q.push_back(b);
      apb(1'b1, OFS_TXDATA, {24'h0, b});
    end
  endtask
  initial begin
    repeat (5000) @(posedge pclk);
    failures++;
    results();
  end
  // ==========================================================================
  // main sequence
  initial begin
    seed = 32'h3b6f;
    failures = 0;
    samples_checked = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, standby, module_standby} = 5'h0;
    paddr = '0;
    pwdata = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b1, OFS_STATUS, 32'h0);
    apb(1'b1, 12'h010, 32'hff);
    rd(OFS_STATUS, 33'h60);
    rd(12'h010, 33'h100000000);
    rd(OFS_CTRL, 33'h0);
    txw(10, 8);
    rd(OFS_TXDATA, 33'h800);
    rd(OFS_STATUS, 33'h60);
    apb(1'b1, OFS_STATUS, 32'hff);
    rd(OFS_STATUS, 33'h60);
    apb(1'b1, OFS_STATUS, 32'h0);
    rd(OFS_STATUS, 33'h40);
    txw(9, 8);
    rd(OFS_TXDATA, 33'h1000);
    apb(1'b1, OFS_CTRL, 32'h10);
    u_sfs_remote.pulse(3'h4);
    txw(1, 1);
    rd(OFS_STATUS, 33'h0);
    repeat (17) u_sfs_remote.pulse(3'h4);
    rd(OFS_STATUS, 33'h20);
    u_sfs_remote.pulse(3'h2);
    rd(OFS_STATUS, 33'h60);
    // even parity, rx trigger 4: good, parity error, framing error, good
    apb(1'b1, OFS_CTRL, 32'h64);
    for (i = 0; i < 4; i++) u_sfs_remote.frame(8'(17 * (i + 1)), i == 1, i == 2, $random(seed) & 3);
    rd(OFS_STATUS, 33'h11e2);
    apb(1'b1, OFS_CTRL, 32'h04);
    rd(OFS_STATUS, 33'h11e2);
    for (i = 0; i < 3; i++) begin
      rd(OFS_RXDATA, 33'(17 * (i + 1)));
      rd(OFS_STATUS, {17'h0, st[i]});
    end
    apb(1'b1, OFS_STATUS, 32'h0);
    rd(OFS_STATUS, 33'h40);
    rd(OFS_RXDATA, 33'h44);
    apb(1'b1, OFS_CTRL, 32'h64);
    u_sfs_remote.frame(8'h55, 1'b0, 1'b0, 0);
    u_sfs_remote.pulse(3'h1);
    rd(OFS_STATUS, 33'h41);
    apb(1'b1, OFS_STATUS, 32'h0);
    rd(OFS_RXDATA, 33'h55);
    // break: the third spacing frame is dropped until the line returns to mark
    for (i = 0; i < 4; i++) u_sfs_remote.frame(i == 3 ? 8'h66 : 8'h00, 1'b0, i < 3, $random(seed) & 3);
    rd(OFS_STATUS, 33'h2d8);
    apb(1'b1, OFS_STATUS, 32'h0);
    rd(OFS_STATUS, 33'h248);
    for (i = 0; i < 3; i++) rd(OFS_RXDATA, i == 2 ? 33'h66 : 33'h0);
    for (i = 0; i < 2; i++) begin
      {module_standby, standby} <= 2'(i + 1);
      repeat (2) @(posedge pclk);
      rd(OFS_STATUS, 33'h60);
      {module_standby, standby} <= 2'h0;
      @(posedge pclk);
    end
    rd(OFS_CTRL, 33'h64);
    // odd parity, tx trigger 4: a correct odd frame, five writes lift the low flag
    apb(1'b1, OFS_CTRL, 32'he5);
    u_sfs_remote.frame(8'h12, 1'b1, 1'b0, 0);
    txw(5, 0);
    rd(OFS_STATUS, 33'h40);
    rd(OFS_TXDATA, 33'h500);
    rd(OFS_RXDATA, 33'h12);
    results();
  end
endmodule
`default_nettype wire
